// file: rtl/lbec_pkg.sv
// Constants and carrier types for the local bus error capture block.
// Assumes a 32-bit APB slave port and a bus clock of 25 MHz.
package lbec_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_DISABLE = 8'h04;
   localparam logic [7:0] OFS_IRQ_EN = 8'h08;
   localparam logic [7:0] OFS_ATTR = 8'h0C;
   localparam logic [7:0] OFS_ADDR = 8'h10;
   localparam logic [7:0] OFS_CONFIG = 8'h14;
   // Error bit positions; bit 0 of the register map is the most significant bit.
   localparam int BIT_MON = 31;
   localparam int BIT_PAR = 29;
   localparam int BIT_WP = 26;
   localparam int BIT_WRITE_FOLLOWS_ATOMIC_READ = 23;
   localparam int BIT_READ_FOLLOWS_ATOMIC_WRITE = 22;
   localparam int BIT_MISS = 19;
   localparam logic [31:0] ERR_MASK = 32'hA4C80000;
   // Attribute capture fields.
   localparam int ATTR_DIR = 28;
   localparam int ATTR_SRC_LO = 16;
   localparam int ATTR_LANE_HI = 15;
   localparam int ATTR_BANK_HI = 11;
   localparam int ATTR_VALID = 0;
   // Monitor count field in the configuration register.
   localparam int CFG_BMT_LO = 8;
   // Reset values.
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [7:0] RST_BMT = 8'h00;
   // Timing in bus clock cycles.
   localparam logic [11:0] MON_MAX_CYC = 12'h800;
   localparam int MON_SHIFT = 3;
   localparam logic [8:0] ATOMIC_WAIT_CYC = 9'h100;

   typedef struct packed {
      logic [31:0] addr;
      logic read;
      logic [4:0] src;
      logic src_valid;
      logic [3:0] bank_hit;
      logic read_only;
      logic atomic;
   } lbec_txn_t;

   typedef struct packed {
      logic [3:0] lanes;
      logic [3:0] bank;
   } lbec_par_t;
endpackage

// file: rtl/lbec_error_capture.sv
// Error detection, status, enables and capture for a local bus controller.
// Assumes transactions are announced by one-cycle pulses synchronous to pclk.
//
// Contract
// - Status reads normally, write-one clears only
// - Unacknowledged transaction past monitor limit sets bit 0
// - Parity error sets bit 2, captures lane, bank
// - Write to read-only region sets bit 5
// - Write-protect violation is not terminated automatically
// - Missing write after atomic read sets bit 8
// - Missing read after atomic write sets bit 9
// - Transaction hitting no bank sets bit 12
// - Disable bits turn off matching error detection
// - Detection and interrupt enables are independent
// - Only enabled error types raise interrupt
// - Clearing status bits negates the interrupt
// - Capture registers frozen while valid bit set
// - Attribute bit 3 holds direction, one read
// - Attribute bits 11-15 hold source identifier
// - Attribute bits 16-19 flag parity byte lanes
// - Attribute bits 20-23 flag failing bank
// - Address capture holds full 32-bit address
// - Monitor count zero means 2048 cycles
`timescale 1ns/1ps
`default_nettype none
module lbec_error_capture (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txn_start,
   input wire lbec_pkg::lbec_txn_t txn,
   input wire logic beat_ack,
   input wire logic txn_end,
   input wire logic par_err,
   input wire lbec_pkg::lbec_par_t par,
   output logic monitor_expired,
   output logic irq
);
   logic [31:0] status_q, status_d, disable_q, irq_en_q, attr_q, addr_q;
   logic [7:0] bmt_q;
   lbec_pkg::lbec_txn_t cur_q, atom_q, cap_txn;
   logic bm_active_q;
   logic [11:0] bm_cnt_q, bm_limit;
   logic war_q, raw_q;
   logic [8:0] war_cnt_q, raw_cnt_q;
   logic bm_hit, wp_ev, miss_ev, war_hit, raw_hit;
   logic [31:0] events, det, clr;
   logic access, wr, mapped, capture;
   logic [3:0] lanes_rev;
   logic [31:0] attr_new;

   assign access = psel & penable;
   assign wr = access & pwrite;
   assign pready = 1'b1;
   assign mapped = (paddr[7:0] == lbec_pkg::OFS_STATUS) | (paddr[7:0] == lbec_pkg::OFS_DISABLE) |
                   (paddr[7:0] == lbec_pkg::OFS_IRQ_EN) | (paddr[7:0] == lbec_pkg::OFS_ATTR) |
                   (paddr[7:0] == lbec_pkg::OFS_ADDR) | (paddr[7:0] == lbec_pkg::OFS_CONFIG);
   assign pslverr = access & ~(mapped & (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'h0));

   // Bus monitor limit; zero selects the longest time-out.
   assign bm_limit = (bmt_q == lbec_pkg::RST_BMT) ? lbec_pkg::MON_MAX_CYC :
                     {1'b0, bmt_q, 3'h0};
   assign bm_hit = bm_active_q & (bm_cnt_q == bm_limit - 12'h001) & ~beat_ack & ~txn_end;

   // Read-only violation is only flagged; the cycle runs on until acknowledged or ended by the monitor.
   assign wp_ev = txn_start & ~txn.read & txn.read_only & (txn.bank_hit != 4'h0);
   assign miss_ev = txn_start & (txn.bank_hit == 4'h0);
   assign war_hit = war_q & (war_cnt_q == lbec_pkg::ATOMIC_WAIT_CYC - 9'h001) &
                    ~(txn_start & ~txn.read);
   assign raw_hit = raw_q & (raw_cnt_q == lbec_pkg::ATOMIC_WAIT_CYC - 9'h001) &
                    ~(txn_start & txn.read);

   always_comb begin
      events = lbec_pkg::RST_ZERO;
      events[lbec_pkg::BIT_MON] = bm_hit;
      events[lbec_pkg::BIT_PAR] = par_err;
      events[lbec_pkg::BIT_WP] = wp_ev;
      events[lbec_pkg::BIT_WRITE_FOLLOWS_ATOMIC_READ] = war_hit;
      events[lbec_pkg::BIT_READ_FOLLOWS_ATOMIC_WRITE] = raw_hit;
      events[lbec_pkg::BIT_MISS] = miss_ev;
   end

   // Detection is gated by the disable bits only, never by the interrupt enables.
   assign det = events & ~disable_q & lbec_pkg::ERR_MASK;
   assign clr = (wr & (paddr[7:0] == lbec_pkg::OFS_STATUS)) ? pwdata : lbec_pkg::RST_ZERO;
   // A new event wins over a clear in the same cycle.
   assign status_d = ((status_q & ~clr) | det) & lbec_pkg::ERR_MASK;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= lbec_pkg::RST_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disable_q <= lbec_pkg::RST_ZERO;
         irq_en_q <= lbec_pkg::RST_ZERO;
         bmt_q <= lbec_pkg::RST_BMT;
      end else if (wr) begin
         if (paddr[7:0] == lbec_pkg::OFS_DISABLE) begin
            disable_q <= pwdata & lbec_pkg::ERR_MASK;
         end
         if (paddr[7:0] == lbec_pkg::OFS_IRQ_EN) begin
            irq_en_q <= pwdata & lbec_pkg::ERR_MASK;
         end
         if (paddr[7:0] == lbec_pkg::OFS_CONFIG) begin
            bmt_q <= pwdata[lbec_pkg::CFG_BMT_LO +: 8];
         end
      end
   end

   // Interrupt follows the enabled status bits one cycle later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & irq_en_q);
      end
   end

   // Transaction tracking and bus monitor.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= '0;
         bm_active_q <= 1'b0;
         bm_cnt_q <= 12'h000;
         monitor_expired <= 1'b0;
      end else begin
         monitor_expired <= bm_hit & ~disable_q[lbec_pkg::BIT_MON];
         if (txn_start) begin
            cur_q <= txn;
            bm_active_q <= 1'b1;
            bm_cnt_q <= 12'h000;
         end else if (bm_active_q) begin
            if (beat_ack | txn_end | bm_hit) begin
               bm_active_q <= 1'b0;
            end
            bm_cnt_q <= bm_cnt_q + 12'h001;
         end
      end
   end

   // Atomic pairing timers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atom_q <= '0;
         war_q <= 1'b0;
         raw_q <= 1'b0;
         war_cnt_q <= 9'h000;
         raw_cnt_q <= 9'h000;
      end else begin
         war_cnt_q <= war_cnt_q + 9'h001;
         raw_cnt_q <= raw_cnt_q + 9'h001;
         if (war_hit | (txn_start & ~txn.read)) begin
            war_q <= 1'b0;
         end
         if (raw_hit | (txn_start & txn.read)) begin
            raw_q <= 1'b0;
         end
         if (txn_start & txn.atomic) begin
            atom_q <= txn;
            if (txn.read) begin
               war_q <= 1'b1;
               war_cnt_q <= 9'h000;
            end else begin
               raw_q <= 1'b1;
               raw_cnt_q <= 9'h000;
            end
         end
      end
   end

   // Capture source: the new transaction for decode errors, the atomic one for pairing errors.
   always_comb begin
      if (det[lbec_pkg::BIT_WP] | det[lbec_pkg::BIT_MISS]) begin
         cap_txn = txn;
      end else if (det[lbec_pkg::BIT_WRITE_FOLLOWS_ATOMIC_READ] | det[lbec_pkg::BIT_READ_FOLLOWS_ATOMIC_WRITE]) begin
         cap_txn = atom_q;
      end else begin
         cap_txn = cur_q;
      end
   end

   // Lane 0 is the most significant byte and lands on the highest field bit.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign lanes_rev[3 - gi] = par.lanes[gi];
      end
   endgenerate

   always_comb begin
      attr_new = lbec_pkg::RST_ZERO;
      attr_new[lbec_pkg::ATTR_DIR] = cap_txn.read;
      attr_new[lbec_pkg::ATTR_SRC_LO +: 5] = cap_txn.src_valid ? cap_txn.src : 5'h00;
      if (det[lbec_pkg::BIT_PAR]) begin
         attr_new[lbec_pkg::ATTR_LANE_HI -: 4] = lanes_rev;
         attr_new[lbec_pkg::ATTR_BANK_HI -: 4] = {par.bank[0], par.bank[1], par.bank[2], par.bank[3]};
      end
      attr_new[lbec_pkg::ATTR_VALID] = 1'b1;
   end

   assign capture = (det != lbec_pkg::RST_ZERO) & ~attr_q[lbec_pkg::ATTR_VALID];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         attr_q <= lbec_pkg::RST_ZERO;
         addr_q <= lbec_pkg::RST_ZERO;
      end else if (capture) begin
         attr_q <= attr_new;
         addr_q <= cap_txn.addr;
      end else if (wr & (paddr[7:0] == lbec_pkg::OFS_ATTR) & pwdata[lbec_pkg::ATTR_VALID]) begin
         attr_q[lbec_pkg::ATTR_VALID] <= 1'b0;
      end
   end

   // Read data is sampled in the setup phase and held through the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= lbec_pkg::RST_ZERO;
      end else if (psel & ~penable) begin
         case (paddr[7:0])
            lbec_pkg::OFS_STATUS: prdata <= status_q;
            lbec_pkg::OFS_DISABLE: prdata <= disable_q;
            lbec_pkg::OFS_IRQ_EN: prdata <= irq_en_q;
            lbec_pkg::OFS_ATTR: prdata <= attr_q;
            lbec_pkg::OFS_ADDR: prdata <= addr_q;
            lbec_pkg::OFS_CONFIG: prdata <= {16'h0000, bmt_q, 8'h00};
            default: prdata <= lbec_pkg::RST_ZERO;
         endcase
      end
   end

   // Cycles since the last transaction start, for checking only.
   logic [11:0] age_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_q <= 12'h000;
      end else if (txn_start) begin
         age_q <= 12'h001;
      end else if (age_q != 12'hFFF) begin
         age_q <= age_q + 12'h001;
      end
   end

   property p_w1c;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr[7:0] == lbec_pkg::OFS_STATUS && det == 32'h00000000)
         |=> ((status_q & $past(pwdata)) == 32'h00000000) &&
             ((status_q & ~$past(pwdata)) == ($past(status_q) & ~$past(pwdata)));
   endproperty
   a_w1c: assert property (p_w1c) else $error("status write did not clear exactly the written ones");

   property p_mon;
      @(posedge pclk) disable iff (!presetn)
      monitor_expired |-> (age_q == (($past(bmt_q) == 8'h00) ? 12'h800 : {1'b0, $past(bmt_q), 3'h0}) + 12'h001);
   endproperty
   a_mon: assert property (p_mon) else $error("monitor time-out at wrong cycle");

   property p_mon_flag;
      @(posedge pclk) disable iff (!presetn)
      monitor_expired |-> status_q[lbec_pkg::BIT_MON];
   endproperty
   a_mon_flag: assert property (p_mon_flag) else $error("monitor time-out not flagged");

   property p_par;
      @(posedge pclk) disable iff (!presetn)
      (par_err && !disable_q[lbec_pkg::BIT_PAR] && !attr_q[lbec_pkg::ATTR_VALID])
         |=> status_q[lbec_pkg::BIT_PAR] && attr_q[lbec_pkg::ATTR_VALID] &&
             attr_q[lbec_pkg::ATTR_LANE_HI] == $past(par.lanes[0]) &&
             attr_q[lbec_pkg::ATTR_BANK_HI] == $past(par.bank[0]);
   endproperty
   a_par: assert property (p_par) else $error("parity error not flagged or captured");

   property p_wp;
      @(posedge pclk) disable iff (!presetn)
      (wp_ev && !disable_q[lbec_pkg::BIT_WP]) |=> status_q[lbec_pkg::BIT_WP] && bm_active_q;
   endproperty
   a_wp: assert property (p_wp) else $error("write-protect not flagged or cycle ended");

   property p_war;
      @(posedge pclk) disable iff (!presetn)
      $rose(war_q) ##1 (!(txn_start && !txn.read))[*8] |-> !status_q[lbec_pkg::BIT_WRITE_FOLLOWS_ATOMIC_READ] || $past(status_q[lbec_pkg::BIT_WRITE_FOLLOWS_ATOMIC_READ], 9);
   endproperty
   a_war: assert property (p_war) else $error("atomic read pairing flagged too early");

   property p_raw;
      @(posedge pclk) disable iff (!presetn)
      (raw_hit && !disable_q[lbec_pkg::BIT_READ_FOLLOWS_ATOMIC_WRITE]) |-> $past(raw_q, 255) ##1 status_q[lbec_pkg::BIT_READ_FOLLOWS_ATOMIC_WRITE];
   endproperty
   a_raw: assert property (p_raw) else $error("atomic write pairing time-out wrong");

   property p_miss;
      @(posedge pclk) disable iff (!presetn)
      (txn_start && txn.bank_hit == 4'h0 && !disable_q[lbec_pkg::BIT_MISS]) |=> status_q[lbec_pkg::BIT_MISS];
   endproperty
   a_miss: assert property (p_miss) else $error("bank miss not flagged");

   property p_dis;
      @(posedge pclk) disable iff (!presetn)
      ((status_q & ~$past(status_q) & $past(disable_q)) == 32'h00000000);
   endproperty
   a_dis: assert property (p_dis) else $error("disabled error was flagged");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      ##1 (irq == |($past(status_q) & $past(irq_en_q)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt does not match enabled status");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (attr_q[lbec_pkg::ATTR_VALID] && $past(attr_q[lbec_pkg::ATTR_VALID]))
         |-> $stable(addr_q) && $stable(attr_q[31:1]);
   endproperty
   a_hold: assert property (p_hold) else $error("capture changed while valid");

   property p_cap;
      @(posedge pclk) disable iff (!presetn)
      capture |=> addr_q == $past(cap_txn.addr) && attr_q[lbec_pkg::ATTR_DIR] == $past(cap_txn.read);
   endproperty
   a_cap: assert property (p_cap) else $error("captured address or direction wrong");

   // A status write may only clear bits, never raise one.
   property p_no_set;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr[7:0] == lbec_pkg::OFS_STATUS && det == 32'h00000000)
         |=> ((status_q & ~$past(status_q)) == 32'h00000000);
   endproperty
   a_no_set: assert property (p_no_set) else $error("status write raised a bit");

   property p_src;
      @(posedge pclk) disable iff (!presetn)
      capture |=> attr_q[lbec_pkg::ATTR_SRC_LO +: 5] ==
                  ($past(cap_txn.src_valid) ? $past(cap_txn.src) : 5'h00);
   endproperty
   a_src: assert property (p_src) else $error("captured source identifier wrong");

   // Lane and bank flags carry meaning only for parity errors, so they stay clear otherwise.
   property p_bank_par;
      @(posedge pclk) disable iff (!presetn)
      (capture && !det[lbec_pkg::BIT_PAR]) |=> attr_q[lbec_pkg::ATTR_LANE_HI -: 8] == 8'h00;
   endproperty
   a_bank_par: assert property (p_bank_par) else $error("bank flags set without parity error");

   property p_valid_clr;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr[7:0] == lbec_pkg::OFS_ATTR && pwdata[lbec_pkg::ATTR_VALID] && !capture)
         |=> !attr_q[lbec_pkg::ATTR_VALID];
   endproperty
   a_valid_clr: assert property (p_valid_clr) else $error("capture valid bit not cleared");

   property p_indep;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr[7:0] == lbec_pkg::OFS_DISABLE) |=> $stable(irq_en_q);
   endproperty
   a_indep: assert property (p_indep) else $error("disable write changed interrupt enables");

   property p_irq_off;
      @(posedge pclk) disable iff (!presetn)
      ((status_q & irq_en_q) == 32'h00000000) |=> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt stayed up after status cleared");

   c_mon: cover property (@(posedge pclk) disable iff (!presetn) monitor_expired);
   c_par_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq) && status_q[lbec_pkg::BIT_PAR]);
   c_atomic: cover property (@(posedge pclk) disable iff (!presetn) war_hit);
   c_recapture: cover property (@(posedge pclk) disable iff (!presetn) capture && $past(attr_q[lbec_pkg::ATTR_VALID], 2));
endmodule
`default_nettype wire

// file: testbench/lbec_bus_model.sv
// Model of the internal initiators and memory banks around the error block.
// Assumes the bench calls its tasks one at a time, from one process.
`timescale 1ns/1ps
`default_nettype none
module lbec_bus_model (
   input wire logic pclk,
   output logic txn_start,
   output lbec_pkg::lbec_txn_t txn,
   output logic beat_ack,
   output logic txn_end,
   output logic par_err,
   output lbec_pkg::lbec_par_t par
);
   initial begin
      txn_start = 1'b0;
      txn = '0;
      beat_ack = 1'b0;
      txn_end = 1'b0;
      par_err = 1'b0;
      par = '0;
   end
   // Starts a transaction and acknowledges its beat after dly cycles.
   task automatic issue(input lbec_pkg::lbec_txn_t t, input int dly);
      @(posedge pclk);
      txn_start <= 1'b1;
      txn <= t;
      @(posedge pclk);
      txn_start <= 1'b0;
      // Qualifiers mean nothing outside the start pulse, so they are scrambled.
      txn <= ~t;
      repeat (dly) @(posedge pclk);
      beat_ack <= 1'b1;
      txn_end <= 1'b1;
      @(posedge pclk);
      beat_ack <= 1'b0;
      txn_end <= 1'b0;
   endtask
   task automatic perr(input lbec_pkg::lbec_par_t p);
      @(posedge pclk);
      par_err <= 1'b1;
      par <= p;
      @(posedge pclk);
      par_err <= 1'b0;
      par <= ~p;
   endtask
endmodule
`default_nettype wire

// file: testbench/local_bus_error_capture_tb.sv
// Self-checking bench for the error capture block with a bus model beside it.
// Assumes zero-wait APB answers and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module local_bus_error_capture_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, txn_start, beat_ack, txn_end, par_err, monitor_expired, irq;
   lbec_pkg::lbec_txn_t txn, t, t2;
   lbec_pkg::lbec_par_t par, p;
   int errors = 0;
   int samples_checked = 0;
   int n;
   logic [31:0] v;
   localparam logic [31:0] MISS = 32'h1 << lbec_pkg::BIT_MISS;
   localparam logic [31:0] WP = 32'h1 << lbec_pkg::BIT_WP;
   localparam logic [31:0] MON = 32'h1 << lbec_pkg::BIT_MON;
   localparam logic [31:0] PAR = 32'h1 << lbec_pkg::BIT_PAR;
   always #20 pclk = ~pclk;
   lbec_error_capture i_lbec_error_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .txn_start(txn_start), .txn(txn), .beat_ack(beat_ack), .txn_end(txn_end), .par_err(par_err),
      .par(par), .monitor_expired(monitor_expired), .irq(irq));
   lbec_bus_model i_lbec_bus_model (.pclk(pclk), .txn_start(txn_start), .txn(txn), .beat_ack(beat_ack),
      .txn_end(txn_end), .par_err(par_err), .par(par));
   task automatic finish_test();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      if (k >= 100) begin
         errors++;
         finish_test();
      end
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      apb(1'b1, a, wd, x);
   endtask
   function automatic lbec_pkg::lbec_txn_t mk(input logic r, input logic ro, input logic [3:0] h, input logic at);
      lbec_pkg::lbec_txn_t x;
      x = '{addr: $urandom, read: r, src: 5'($urandom), src_valid: 1'($urandom), bank_hit: h, read_only: ro,
            atomic: at};
      return x;
   endfunction
   function automatic logic [31:0] attr_exp(input lbec_pkg::lbec_txn_t x);
      logic [31:0] r;
      r = 32'h0;
      r[lbec_pkg::ATTR_DIR] = x.read;
      r[lbec_pkg::ATTR_SRC_LO+:5] = x.src_valid ? x.src : 5'h0;
      r[lbec_pkg::ATTR_VALID] = 1'b1;
      return r;
   endfunction
   initial begin
      void'($urandom(32'h5A82));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0, rd);
         `CHK("reset value", 32'h0, rd)
      end
      apb(1'b0, 8'h18, 32'h0, rd);
      `CHK("unmapped error", 1'b1, pslverr)
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(lbec_pkg::OFS_DISABLE, v);
         wr(lbec_pkg::OFS_IRQ_EN, ~v);
         apb(1'b0, lbec_pkg::OFS_DISABLE, 32'h0, rd);
         `CHK("disable", v & lbec_pkg::ERR_MASK, rd)
         apb(1'b0, lbec_pkg::OFS_IRQ_EN, 32'h0, rd);
         `CHK("irq enable", ~v & lbec_pkg::ERR_MASK, rd)
         `CHK("irq no status", 1'b0, irq)
      end
      wr(lbec_pkg::OFS_DISABLE, 32'h0);
      wr(lbec_pkg::OFS_STATUS, 32'hFFFFFFFF);
      wr(lbec_pkg::OFS_IRQ_EN, WP);
      t = mk(1'($urandom), 1'b0, 4'h0, 1'b0);
      i_lbec_bus_model.issue(t, 3);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("miss status", MISS, rd)
      `CHK("irq masked", 1'b0, irq)
      apb(1'b0, lbec_pkg::OFS_ATTR, 32'h0, rd);
      `CHK("attr", attr_exp(t), rd)
      t2 = mk(1'b0, 1'b1, 4'h2, 1'b0);
      i_lbec_bus_model.issue(t2, 3);
      repeat (2) @(posedge pclk);
      `CHK("irq wp", 1'b1, irq)
      apb(1'b0, lbec_pkg::OFS_ADDR, 32'h0, rd);
      `CHK("frozen addr", t.addr, rd)
      wr(lbec_pkg::OFS_STATUS, ~(MISS | WP));
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("w1c zeros", MISS | WP, rd)
      wr(lbec_pkg::OFS_STATUS, WP);
      repeat (2) @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("w1c one", MISS, rd)
      wr(lbec_pkg::OFS_STATUS, 32'hFFFFFFFF);
      wr(lbec_pkg::OFS_ATTR, 32'h1);
      p = '{lanes: 4'($urandom) | 4'h1, bank: 4'h1 << ($urandom % 4)};
      i_lbec_bus_model.perr(p);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("parity status", PAR, rd)
      apb(1'b0, lbec_pkg::OFS_ATTR, 32'h0, rd);
      v = 32'h00000001;
      for (int i = 0; i < 4; i++) begin
         v[lbec_pkg::ATTR_LANE_HI - i] = p.lanes[i];
         v[lbec_pkg::ATTR_BANK_HI - i] = p.bank[i];
      end
      `CHK("lanes bank", v, rd & 32'h0000FF01)
      wr(lbec_pkg::OFS_STATUS, 32'hFFFFFFFF);
      wr(lbec_pkg::OFS_DISABLE, PAR | MISS);
      i_lbec_bus_model.perr(p);
      i_lbec_bus_model.issue(t, 3);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("disabled", 32'h0, rd)
      apb(1'b0, lbec_pkg::OFS_IRQ_EN, 32'h0, rd);
      `CHK("enable kept", WP, rd)
      wr(lbec_pkg::OFS_DISABLE, 32'h0);
      for (int b = 0; b < 2; b++) begin
         wr(lbec_pkg::OFS_CONFIG, b ? 32'h0 : 32'h5 << lbec_pkg::CFG_BMT_LO);
         fork
            i_lbec_bus_model.issue(t2, b ? 2100 : 60);
            begin
               n = 0;
               while (txn_start !== 1'b1) @(negedge pclk);
               do begin
                  @(negedge pclk);
                  n++;
               end while (monitor_expired !== 1'b1 && n < 3000);
            end
         join
         `CHK("monitor delay", 1'b1, n >= (b ? 2048 : 40) && n <= (b ? 2050 : 42))
         apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
         `CHK("wp then monitor", WP | MON, rd)
         wr(lbec_pkg::OFS_STATUS, 32'hFFFFFFFF);
      end
      i_lbec_bus_model.issue(mk(1'b1, 1'b0, 4'h1, 1'b1), 2);
      repeat (300) @(posedge pclk);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("atomic read alone", 32'h1 << lbec_pkg::BIT_WRITE_FOLLOWS_ATOMIC_READ, rd)
      wr(lbec_pkg::OFS_STATUS, 32'hFFFFFFFF);
      i_lbec_bus_model.issue(mk(1'b0, 1'b0, 4'h4, 1'b1), 2);
      repeat (100) @(posedge pclk);
      i_lbec_bus_model.issue(mk(1'b1, 1'b0, 4'h4, 1'b0), 2);
      repeat (300) @(posedge pclk);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("atomic paired", 32'h0, rd)
      i_lbec_bus_model.issue(mk(1'b0, 1'b0, 4'h8, 1'b1), 2);
      repeat (300) @(posedge pclk);
      apb(1'b0, lbec_pkg::OFS_STATUS, 32'h0, rd);
      `CHK("atomic write alone", 32'h1 << lbec_pkg::BIT_READ_FOLLOWS_ATOMIC_WRITE, rd)
      finish_test();
   end
endmodule
`default_nettype wire
